// *** common/wprot_pkg.sv ***
// constants for the peripheral write-protect register slice
// assumes a simple word-wide register port on the peripheral bus clock
package wprot_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CLEAR = 8'h00;
  localparam logic [7:0] OFS_SET = 8'h04;
  // bridge instance 0: bits 6..1
  localparam logic [31:0] MASK_BR0 = 32'h0000_007e;
  localparam logic [31:0] RST_BR0 = 32'h0000_0000;
  // bridge instance 1: bits 6,3,2,1; debug service unit starts protected
  localparam logic [31:0] MASK_BR1 = 32'h0000_004e;
  localparam logic [31:0] RST_BR1 = 32'h0000_0002;
  // bridge instance 2: bit 16 adc, 15..8 timers, 7..2 serial units, 1 event routing
  localparam logic [31:0] MASK_BR2 = 32'h0001_fffe;
  localparam logic [31:0] RST_BR2 = 32'h0000_0000;
  localparam int unsigned POS_EVENT_ROUTING = 1;
  localparam int unsigned POS_SERIAL_LO = 2;
  localparam int unsigned POS_TIMER_LO = 8;
  localparam int unsigned POS_ADC = 16;
endpackage

// *** sim/cpu_model.sv ***
// processor model making one-cycle register accesses
// assumes the block samples requests on the rising mclk_in edge
`timescale 1ns/10ps
module cpu_model (
  input wire logic mclk_in,
  output logic sel_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out
);
  initial {sel_out, wr_out, addr_out, wdata_out} = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in) #1;
    {sel_out, wr_out, addr_out, wdata_out} = {1'b1, w, a, d};
    @(posedge mclk_in) #1;
    // released data flips so a stale word is never mistaken for a request
    {sel_out, wdata_out} = {1'b0, ~d};
  endtask
endmodule

// *** sim/peripheral_write_protect_regs_test.sv ***
// self-checking bench for the write-protect slice, third bridge
// assumes cpu_model drives the register port
`timescale 1ns/10ps
module peripheral_write_protect_regs_test;
  import wprot_pkg::*;
  logic mclk_in = 0, sys_rst_in = 1, sel, wr, pw = 0, err, ok, perr;
  logic [7:0] addr;
  logic [4:0] pidx = 5'h08;
  logic [31:0] wd, rd, prot;
  int n_fail = 0, compares = 0;
  initial forever #4 mclk_in = ~mclk_in;
  cpu_model cpu_model_i (.mclk_in(mclk_in), .sel_out(sel), .wr_out(wr), .addr_out(addr), .wdata_out(wd));
  peripheral_write_protect_regs peripheral_write_protect_regs_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_sel_in(sel), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rd),
    .reg_err_out(err), .periph_wr_in(pw), .periph_idx_in(pidx), .periph_wr_ok_out(ok),
    .periph_err_out(perr), .protect_out(prot));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic set_timer;
    cpu_model_i.acc(1'b1, OFS_SET, 32'h0000_0100);
    chk(prot, 32'h0000_0100);
    chk({31'h0, err}, 32'h0);
    cpu_model_i.acc(1'b0, OFS_CLEAR, 32'h0);
    chk(rd, 32'h0000_0100);
  endtask
  task automatic double_and_zero;
    cpu_model_i.acc(1'b1, OFS_SET, 32'h0000_0100);
    chk({31'h0, err}, 32'h1);
    cpu_model_i.acc(1'b1, OFS_CLEAR, 32'h0);
    chk(prot, 32'h0000_0100);
  endtask
  task automatic blocked_write;
    @(posedge mclk_in) #1 pw = 1'b1;
    #1 chk({31'h0, ok}, 32'h0);
    @(posedge mclk_in) #1 pidx = 5'h09;
    chk({31'h0, perr}, 32'h1);
    #1 chk({31'h0, ok}, 32'h1);
    @(posedge mclk_in) #1 pw = 1'b0;
    chk({31'h0, perr}, 32'h0);
  endtask
  task automatic serial_and_loose;
    cpu_model_i.acc(1'b1, OFS_SET, 32'h8000_00fd);
    chk(prot, 32'h0000_01fc);
    chk({31'h0, err}, 32'h0);
    cpu_model_i.acc(1'b1, OFS_CLEAR, 32'h0001_ffff);
    chk(prot, 32'h0);
    chk({31'h0, err}, 32'h1);
    cpu_model_i.acc(1'b0, OFS_SET, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic unmapped;
    cpu_model_i.acc(1'b1, OFS_SET, 32'h0000_0200);
    cpu_model_i.acc(1'b1, 8'h08, 32'h0000_0200);
    chk(prot, 32'h0000_0200);
    chk({31'h0, err}, 32'h0);
    cpu_model_i.acc(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic reset_mid;
    cpu_model_i.acc(1'b1, OFS_SET, 32'h0001_fd02);
    chk(prot, 32'h0001_ff02);
    chk({31'h0, err}, 32'h0);
    @(posedge mclk_in) #1 sys_rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    chk(prot, RST_BR2);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    chk(prot, RST_BR2);
    set_timer();
    double_and_zero();
    blocked_write();
    serial_and_loose();
    unmapped();
    reset_mid();
    complete_run();
  end
endmodule

// *** verilog/peripheral_write_protect_regs.sv ***
// protection state registers for one bridge instance, plus per-peripheral write gating
// assumes the register port and peripheral write requests are on mclk_in
`timescale 1ns/10ps
// Behaviour
// - writing zero to any protection bit leaves that peripheral's state alone.
// - writing one to a clear-register bit unprotects that peripheral, read as 0.
// - in bridge two, bits 15..8 guard the timers, bit 16 the adc and bit 1 event routing.
// - in bridge two, bits 7..2 guard the six serial units in ascending order.
// - writing one to a set-register bit protects that peripheral in the shared state.
// - reads of set and clear registers return the same shared state.
// - a write to a protected peripheral is dropped and answered with an access error.
// - protecting an already protected or unprotecting an unprotected peripheral errors.
module peripheral_write_protect_regs #(
  parameter int unsigned BRIDGE = 2
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [wprot_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [wprot_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [wprot_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_err_out,
  input wire logic periph_wr_in,
  input wire logic [4:0] periph_idx_in,
  output logic periph_wr_ok_out,
  output logic periph_err_out,
  output logic [wprot_pkg::DATA_W-1:0] protect_out
);
  import wprot_pkg::*;

  localparam logic [31:0] MASK = (BRIDGE == 0) ? MASK_BR0 : (BRIDGE == 1) ? MASK_BR1 : MASK_BR2;
  localparam logic [31:0] RST = (BRIDGE == 0) ? RST_BR0 : (BRIDGE == 1) ? RST_BR1 : RST_BR2;

  typedef struct packed {
    logic [31:0] prot;
    logic [31:0] rdata;
    logic err;
    logic perr;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [31:0] wbits;
  logic hit_clr;
  logic hit_set;
  logic hit_rd;
  logic blocked;
  // per-bit next state and double-operation flags, filled by the cell loop
  logic [31:0] cell_nxt;
  logic [31:0] cell_dup;

  // request decode; an unmapped offset matches neither register and is ignored
  assign hit_clr = reg_sel_in && reg_wr_in && (reg_addr_in == OFS_CLEAR);
  assign hit_set = reg_sel_in && reg_wr_in && (reg_addr_in == OFS_SET);
  assign hit_rd = reg_sel_in && !reg_wr_in && (reg_addr_in == OFS_CLEAR || reg_addr_in == OFS_SET);
  assign wbits = reg_wdata_in & MASK;
  assign blocked = st_ff.prot[periph_idx_in];

  // one cell per bit; positions without a peripheral are tied off, so a stray one
  // written there can neither change state nor raise an error
  for (genvar b = 0; b < 32; b++)
  begin : g_cell
    if (MASK[b])
    begin : g_live
      assign cell_nxt[b] = (hit_clr && wbits[b]) ? 1'b0 :
        ((hit_set && wbits[b]) ? 1'b1 : st_ff.prot[b]);
      assign cell_dup[b] = wbits[b] && ((hit_clr && !st_ff.prot[b]) || (hit_set && st_ff.prot[b]));
      bit_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (hit_clr && reg_wdata_in[b])
        |=> !protect_out[b])
        else $error("cleared bit still protected");
      bit_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (hit_set && reg_wdata_in[b])
        |=> protect_out[b])
        else $error("set bit not protected");
      bit_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !((hit_clr || hit_set) && reg_wdata_in[b])
        |=> $stable(protect_out[b]))
        else $error("unwritten bit changed");
      bit_double_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (reg_wdata_in[b] && ((hit_set && protect_out[b]) || (hit_clr && !protect_out[b])))
        |=> reg_err_out)
        else $error("double operation not flagged");
    end
    else
    begin : g_tied
      assign cell_nxt[b] = 1'b0;
      assign cell_dup[b] = 1'b0;
      bit_tied_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !protect_out[b] && !reg_rdata_out[b])
        else $error("unassigned bit not zero");
    end
  end

  // the shared state answers both offsets; only a read request drives rdata
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.prot = cell_nxt;
    nxt_st.err = |cell_dup;
    nxt_st.perr = periph_wr_in && blocked;
    nxt_st.rdata = 32'h0000_0000;
    if (hit_rd)
    begin
      nxt_st.rdata = st_ff.prot & MASK;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      st_ff <= '{prot: RST, rdata: 32'h0000_0000, err: 1'b0, perr: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // write gate is combinational so a blocked write never reaches the peripheral
  assign periph_wr_ok_out = periph_wr_in && !blocked;
  assign periph_err_out = st_ff.perr;
  assign reg_rdata_out = st_ff.rdata;
  assign reg_err_out = st_ff.err;
  assign protect_out = st_ff.prot;

  zero_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hit_clr || hit_set) |=> ((protect_out & ~$past(wbits)) == ($past(protect_out) & ~$past(wbits))))
    else $error("unwritten protection bit changed");
  clear_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    hit_clr |=> ((protect_out & $past(wbits)) == 32'h0000_0000))
    else $error("clear did not unprotect");
  set_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    hit_set |=> ((protect_out & $past(wbits)) == $past(wbits)))
    else $error("set did not protect");
  read_same_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (reg_sel_in && !reg_wr_in && (reg_addr_in == OFS_SET || reg_addr_in == OFS_CLEAR))
    |=> (reg_rdata_out == ($past(protect_out) & MASK)))
    else $error("read value differs from state");
  blocked_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (periph_wr_in && protect_out[periph_idx_in]) |-> !periph_wr_ok_out ##1 periph_err_out)
    else $error("protected write not blocked");
  double_op_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hit_set && |(wbits & protect_out)) |=> reg_err_out)
    else $error("double protect not flagged");
  unassigned_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ((protect_out & ~MASK) == 32'h0000_0000) && ((reg_rdata_out & ~MASK) == 32'h0000_0000))
    else $error("unassigned bit set");
  map_bits_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (BRIDGE != 2) || (MASK[POS_ADC] && MASK[POS_EVENT_ROUTING] && (MASK[POS_TIMER_LO+7:POS_SERIAL_LO] == 14'h3fff)))
    else $error("bridge two bit map wrong");

  // register side: an error pulse only follows a write that repeats the current state
  dup_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hit_clr && ((reg_wdata_in & MASK & ~protect_out) != 32'h0000_0000))
    |=> reg_err_out)
    else $error("double unprotect not flagged");

  clean_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hit_clr && ((reg_wdata_in & MASK & ~protect_out) == 32'h0000_0000))
    |=> !reg_err_out)
    else $error("clean clear flagged");

  clean_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (hit_set && ((reg_wdata_in & MASK & protect_out) == 32'h0000_0000))
    |=> !reg_err_out)
    else $error("clean set flagged");

  err_cause_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !(reg_sel_in && reg_wr_in)
    |=> !reg_err_out)
    else $error("error without a write");

  read_idle_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !(reg_sel_in && !reg_wr_in)
    |=> (reg_rdata_out == 32'h0000_0000))
    else $error("read data without a read");

  read_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (reg_sel_in && !reg_wr_in && (reg_addr_in == OFS_CLEAR))
    |=> (reg_rdata_out == $past(protect_out)))
    else $error("clear register read wrong");

  read_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (reg_sel_in && !reg_wr_in && (reg_addr_in == OFS_SET))
    |=> (reg_rdata_out == $past(protect_out)))
    else $error("set register read wrong");

  state_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !(reg_sel_in && reg_wr_in)
    |=> $stable(protect_out))
    else $error("state changed without a write");

  unmapped_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (reg_sel_in && (reg_addr_in != OFS_CLEAR) && (reg_addr_in != OFS_SET))
    |=> ($stable(protect_out) && !reg_err_out && (reg_rdata_out == 32'h0000_0000)))
    else $error("unmapped access had an effect");

  // no disable here: this one watches the reset itself
  reset_state_a: assert property (@(posedge mclk_in)
    sys_rst_in
    |=> ((protect_out == RST) && (reg_rdata_out == 32'h0000_0000) && !reg_err_out && !periph_err_out))
    else $error("reset state wrong");

  // peripheral side
  open_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (periph_wr_in && !protect_out[periph_idx_in])
    |-> periph_wr_ok_out ##1 !periph_err_out)
    else $error("unprotected write refused");

  idle_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !periph_wr_in
    |-> !periph_wr_ok_out ##1 !periph_err_out)
    else $error("gate active without a write");

  write_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    periph_wr_ok_out
    |-> (periph_wr_in && !protect_out[periph_idx_in]))
    else $error("write passed while protected");

  perr_cause_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    periph_err_out
    |-> $past(periph_wr_in))
    else $error("access error without a write");
endmodule
